// file: rtl/rrs_pkg.sv
// Constants, types and register map of the rotate-right and set-file execute block.
package rrs_pkg;

	// ==========================================================
	// Register map (byte addresses on the AXI4-Lite bus)
	localparam logic [7:0] OFF_INSTR = 8'h00;
	localparam logic [7:0] OFF_CFG = 8'h04;
	localparam logic [7:0] OFF_BANK = 8'h08;
	localparam logic [7:0] OFF_WREG = 8'h0c;
	localparam logic [7:0] OFF_STAT = 8'h10;
	localparam logic [7:0] OFF_IDX = 8'h14;
	localparam logic [7:0] OFF_MADDR = 8'h18;
	localparam logic [7:0] OFF_MDATA = 8'h1c;

	// ==========================================================
	// Field positions
	localparam int CFG_EXT = 0;
	localparam int STAT_C = 0;
	localparam int STAT_DC = 1;
	localparam int STAT_Z = 2;
	localparam int STAT_OV = 3;
	localparam int STAT_N = 4;
	localparam int STAT_BUSY = 8;
	localparam int STAT_ILLEGAL = 9;
	localparam int INS_DEST = 9;
	localparam int INS_ACC = 8;

	// ==========================================================
	// Opcodes, addressing and answers
	localparam logic [5:0] OPC_ROT = 6'h10;
	localparam logic [6:0] OPC_SET = 7'h34;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [7:0] LOW_LIMIT = 8'h5f;
	localparam logic [3:0] LOW_BANK = 4'h0;
	localparam logic [3:0] HIGH_BANK = 4'hf;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_ERR = 2'h2;

	// ==========================================================
	// Types
	typedef enum logic [2:0] {PH_IDLE, PH_DECODE, PH_READ, PH_PROCESS, PH_WRITE} rrs_phase_t;
	typedef enum logic [1:0] {OP_NONE, OP_ROT, OP_SET} rrs_op_t;

	typedef struct packed {
		rrs_phase_t phase;
		rrs_op_t op;
		logic [15:0] instr;
		logic [11:0] ea;
		logic [7:0] operand;
		logic [7:0] result;
		logic destFile;
		logic illegal;
		logic extEn;
		logic [3:0] bank;
		logic [7:0] wreg;
		logic [4:0] status;
		logic [11:0] idxBase;
		logic [11:0] memAddr;
		logic awHeld;
		logic [7:0] awAddr;
		logic wHeld;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rrs_state_t;

	localparam rrs_state_t STATE_RESET = '0;

endpackage : rrs_pkg

// file: rtl/rrs_file_mem.sv
// Byte-wide data memory with two combinational read ports and one write port.
`timescale 1ns/1ps
module rrs_file_mem #(
	parameter int ADDR_W = 12
) (
	// Clock.
	input wire logic clock,
	// Read ports.
	input wire logic [ADDR_W-1:0] rdAddrA,
	output logic [7:0] rdDataA,
	input wire logic [ADDR_W-1:0] rdAddrB,
	output logic [7:0] rdDataB,
	// Write port.
	input wire logic wrEn,
	input wire logic [ADDR_W-1:0] wrAddr,
	input wire logic [7:0] wrData
);

	// ==========================================================
	// Storage
	// The array has no reset; software must initialise the bytes it relies on.
	logic [7:0] mem [0:(1<<ADDR_W)-1];

	initial begin
		if (ADDR_W != 12) $error("rrs_file_mem needs a 12-bit address.");
	end

	always_ff @(posedge clock) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	assign rdDataA = mem[rdAddrA];
	assign rdDataB = mem[rdAddrB];

endmodule : rrs_file_mem

// file: rtl/rrs_exec.sv
// Execute unit for rotate-right-no-carry and set-file-all-ones with an AXI4-Lite register slave.
//
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module rrs_exec #(
	parameter int ADDR_W = 8
) (
	// Clock and reset.
	input wire logic clock,
	input wire logic rstn,
	// AXI4-Lite write channels.
	input wire logic awvalid,
	output logic awready,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// AXI4-Lite read channels.
	input wire logic arvalid,
	output logic arready,
	input wire logic [ADDR_W-1:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp
);

	initial begin
		if (ADDR_W < 8) $error("rrs_exec needs at least 8 address bits.");
	end

	rrs_pkg::rrs_state_t cur;
	rrs_pkg::rrs_state_t next_cur;
	logic [7:0] memRdA;
	logic [7:0] memRdB;
	logic memWe;
	logic [11:0] memWa;
	logic [7:0] memWd;
	logic busy;
	logic busWrite;

	// ==========================================================
	// Helpers
	function automatic logic [11:0] operandAddr(input logic acc, input logic [7:0] f, input logic ext,
			input logic [3:0] bank, input logic [11:0] idx);
		if (acc) begin
			operandAddr = {bank, f};
		end else if (ext && f <= rrs_pkg::LOW_LIMIT) begin
			operandAddr = idx + {4'h0, f};
		end else if (f <= rrs_pkg::LOW_LIMIT) begin
			operandAddr = {rrs_pkg::LOW_BANK, f};
		end else begin
			operandAddr = {rrs_pkg::HIGH_BANK, f};
		end
	endfunction : operandAddr

	function automatic logic [15:0] mergeLow(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		mergeLow = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : mergeLow

	// ==========================================================
	// Memory
	rrs_file_mem #(.ADDR_W(12)) uMem (
		.clock(clock),
		.rdAddrA(cur.ea),
		.rdDataA(memRdA),
		.rdAddrB(cur.memAddr),
		.rdDataB(memRdB),
		.wrEn(memWe),
		.wrAddr(memWa),
		.wrData(memWd)
	);

	assign busy = cur.phase != rrs_pkg::PH_IDLE;
	// A bus write waits while the core writes back, so the two never touch the same state.
	assign busWrite = cur.awHeld && cur.wHeld && !cur.bvalid && cur.phase != rrs_pkg::PH_WRITE;
	assign awready = !cur.awHeld;
	assign wready = !cur.wHeld;
	assign arready = !cur.rvalid;
	assign bvalid = cur.bvalid;
	assign bresp = cur.bresp;
	assign rvalid = cur.rvalid;
	assign rdata = cur.rdata;
	assign rresp = cur.rresp;

	// ==========================================================
	// Next state
	always_comb begin
		logic [15:0] m;
		logic [7:0] a;
		m = '0;
		a = '0;
		next_cur = cur;
		memWe = 1'b0;
		memWa = cur.ea;
		memWd = cur.result;

		if (awvalid && !cur.awHeld) begin
			next_cur.awHeld = 1'b1;
			next_cur.awAddr = awaddr[7:0];
		end
		if (wvalid && !cur.wHeld) begin
			next_cur.wHeld = 1'b1;
			next_cur.wData = wdata;
			next_cur.wStrb = wstrb;
		end
		if (cur.bvalid && bready) begin
			next_cur.bvalid = 1'b0;
		end
		if (busWrite) begin
			m = mergeLow(16'h0000, cur.wData, cur.wStrb);
			next_cur.awHeld = 1'b0;
			next_cur.wHeld = 1'b0;
			next_cur.bvalid = 1'b1;
			next_cur.bresp = rrs_pkg::RESP_OK;
			if (cur.awAddr == rrs_pkg::OFF_INSTR) begin
				if (busy) begin
					next_cur.bresp = rrs_pkg::RESP_ERR;
				end else begin
					next_cur.instr = mergeLow(cur.instr, cur.wData, cur.wStrb);
					next_cur.illegal = 1'b0;
					next_cur.phase = rrs_pkg::PH_DECODE;
				end
			end else if (cur.awAddr == rrs_pkg::OFF_CFG) begin
				if (cur.wStrb[0]) next_cur.extEn = m[rrs_pkg::CFG_EXT];
			end else if (cur.awAddr == rrs_pkg::OFF_BANK) begin
				if (cur.wStrb[0]) next_cur.bank = m[3:0];
			end else if (cur.awAddr == rrs_pkg::OFF_WREG) begin
				if (cur.wStrb[0]) next_cur.wreg = m[7:0];
			end else if (cur.awAddr == rrs_pkg::OFF_STAT) begin
				if (cur.wStrb[0]) next_cur.status = m[4:0];
			end else if (cur.awAddr == rrs_pkg::OFF_IDX) begin
				next_cur.idxBase = 12'(mergeLow({4'h0, cur.idxBase}, cur.wData, cur.wStrb));
			end else if (cur.awAddr == rrs_pkg::OFF_MADDR) begin
				next_cur.memAddr = 12'(mergeLow({4'h0, cur.memAddr}, cur.wData, cur.wStrb));
			end else if (cur.awAddr == rrs_pkg::OFF_MDATA) begin
				memWe = cur.wStrb[0];
				memWa = cur.memAddr;
				memWd = cur.wData[7:0];
			end else begin
				next_cur.bresp = rrs_pkg::RESP_ERR;
			end
		end

		if (cur.rvalid && rready) begin
			next_cur.rvalid = 1'b0;
		end
		if (arvalid && !cur.rvalid) begin
			a = araddr[7:0];
			next_cur.rvalid = 1'b1;
			next_cur.rresp = rrs_pkg::RESP_OK;
			next_cur.rdata = '0;
			if (a == rrs_pkg::OFF_INSTR) begin
				next_cur.rdata[15:0] = cur.instr;
			end else if (a == rrs_pkg::OFF_CFG) begin
				next_cur.rdata[rrs_pkg::CFG_EXT] = cur.extEn;
			end else if (a == rrs_pkg::OFF_BANK) begin
				next_cur.rdata[3:0] = cur.bank;
			end else if (a == rrs_pkg::OFF_WREG) begin
				next_cur.rdata[7:0] = cur.wreg;
			end else if (a == rrs_pkg::OFF_STAT) begin
				next_cur.rdata[4:0] = cur.status;
				next_cur.rdata[rrs_pkg::STAT_BUSY] = busy;
				next_cur.rdata[rrs_pkg::STAT_ILLEGAL] = cur.illegal;
			end else if (a == rrs_pkg::OFF_IDX) begin
				next_cur.rdata[11:0] = cur.idxBase;
			end else if (a == rrs_pkg::OFF_MADDR) begin
				next_cur.rdata[11:0] = cur.memAddr;
			end else if (a == rrs_pkg::OFF_MDATA) begin
				next_cur.rdata[7:0] = memRdB;
			end else begin
				next_cur.rresp = rrs_pkg::RESP_ERR;
			end
		end

		case (cur.phase)
			rrs_pkg::PH_DECODE: begin
				next_cur.ea = operandAddr(cur.instr[rrs_pkg::INS_ACC], cur.instr[7:0], cur.extEn, cur.bank,
					cur.idxBase);
				next_cur.phase = rrs_pkg::PH_READ;
				if (cur.instr[15:10] == rrs_pkg::OPC_ROT) begin
					next_cur.op = rrs_pkg::OP_ROT;
					next_cur.destFile = cur.instr[rrs_pkg::INS_DEST];
				end else if (cur.instr[15:9] == rrs_pkg::OPC_SET) begin
					next_cur.op = rrs_pkg::OP_SET;
					next_cur.destFile = 1'b1;
				end else begin
					next_cur.op = rrs_pkg::OP_NONE;
					next_cur.illegal = 1'b1;
					next_cur.phase = rrs_pkg::PH_IDLE;
				end
			end
			rrs_pkg::PH_READ: begin
				next_cur.operand = memRdA;
				next_cur.phase = rrs_pkg::PH_PROCESS;
			end
			rrs_pkg::PH_PROCESS: begin
				if (cur.op == rrs_pkg::OP_ROT) begin
					next_cur.result = {cur.operand[0], cur.operand[7:1]};
				end else begin
					next_cur.result = rrs_pkg::ALL_ONES;
				end
				next_cur.phase = rrs_pkg::PH_WRITE;
			end
			rrs_pkg::PH_WRITE: begin
				memWe = cur.destFile;
				memWa = cur.ea;
				memWd = cur.result;
				if (!cur.destFile) next_cur.wreg = cur.result;
				if (cur.op == rrs_pkg::OP_ROT) begin
					next_cur.status[rrs_pkg::STAT_N] = cur.result[7];
					next_cur.status[rrs_pkg::STAT_Z] = cur.result == 8'h00;
				end
				next_cur.phase = rrs_pkg::PH_IDLE;
			end
			default: begin
			end
		endcase
	end

	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cur <= rrs_pkg::STATE_RESET;
		end else begin
			cur <= next_cur;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);

	chk_rot_result: assert property (cur.phase == rrs_pkg::PH_PROCESS && cur.op == rrs_pkg::OP_ROT |=>
		cur.result == {$past(cur.operand[0]), $past(cur.operand[7:1])}) else $error("Rotate result wrong.");
	chk_dest_work: assert property (cur.phase == rrs_pkg::PH_WRITE && !cur.destFile |->
		!memWe ##1 cur.wreg == $past(cur.result)) else $error("Working register not written.");
	chk_dest_file: assert property (cur.phase == rrs_pkg::PH_WRITE && cur.destFile |->
		memWe && memWa == cur.ea ##1 $stable(cur.wreg)) else $error("File write-back wrong.");
	chk_access_bank: assert property (cur.phase == rrs_pkg::PH_DECODE && !cur.instr[8] &&
		!(cur.extEn && cur.instr[7:0] <= 8'h5f) |=> cur.ea[7:0] == $past(cur.instr[7:0]) &&
		cur.ea[11:8] == ($past(cur.instr[7:0]) <= 8'h5f ? 4'h0 : 4'hf)) else $error("Access bank wrong.");
	chk_bank_select: assert property (cur.phase == rrs_pkg::PH_DECODE && cur.instr[8] |=>
		cur.ea == {$past(cur.bank), $past(cur.instr[7:0])}) else $error("Banked address wrong.");
	chk_indexed_mode: assert property (cur.phase == rrs_pkg::PH_DECODE && !cur.instr[8] && cur.extEn &&
		cur.instr[7:0] <= 8'h5f |=> cur.ea == 12'($past(cur.idxBase) + $past(cur.instr[7:0])))
		else $error("Indexed address wrong.");
	chk_rot_flags: assert property (cur.phase == rrs_pkg::PH_WRITE && cur.op == rrs_pkg::OP_ROT |=>
		cur.status[4] == $past(cur.result[7]) && cur.status[2] == ($past(cur.result) == 8'h00) &&
		cur.status[1:0] == $past(cur.status[1:0]) && cur.status[3] == $past(cur.status[3]))
		else $error("Rotate flags wrong.");
	chk_four_phases: assert property (cur.phase == rrs_pkg::PH_DECODE &&
		(cur.instr[15:10] == 6'h10 || cur.instr[15:9] == 7'h34) |=> cur.phase == rrs_pkg::PH_READ ##1
		cur.phase == rrs_pkg::PH_PROCESS ##1 cur.phase == rrs_pkg::PH_WRITE ##1 cur.phase == rrs_pkg::PH_IDLE)
		else $error("Phase sequence wrong.");
	chk_set_value: assert property (cur.phase == rrs_pkg::PH_WRITE && cur.op == rrs_pkg::OP_SET |->
		memWe && memWd == 8'hff) else $error("Set-file value wrong.");
	chk_set_flags: assert property (cur.phase == rrs_pkg::PH_WRITE && cur.op == rrs_pkg::OP_SET |=>
		$stable(cur.status)) else $error("Set-file changed flags.");
	chk_set_address: assert property (cur.phase == rrs_pkg::PH_DECODE && cur.instr[15:9] == 7'h34 |=>
		cur.ea == ($past(cur.instr[8]) ? {$past(cur.bank), $past(cur.instr[7:0])} :
		($past(cur.extEn) && $past(cur.instr[7:0]) <= 8'h5f) ? 12'($past(cur.idxBase) + $past(cur.instr[7:0])) :
		{($past(cur.instr[7:0]) <= 8'h5f ? 4'h0 : 4'hf), $past(cur.instr[7:0])}))
		else $error("Set-file address wrong.");

	cov_rot_to_w: cover property (cur.phase == rrs_pkg::PH_WRITE && cur.op == rrs_pkg::OP_ROT && !cur.destFile);
	cov_set_indexed: cover property (cur.phase == rrs_pkg::PH_DECODE && cur.instr[15:9] == 7'h34 &&
		!cur.instr[8] && cur.extEn && cur.instr[7:0] <= 8'h5f);
	cov_illegal: cover property (cur.phase == rrs_pkg::PH_DECODE ##1 cur.illegal);

endmodule : rrs_exec

// file: bench/test_rrs_exec.sv
// Self-checking bench for the rotate-right and set-file execute block.
`timescale 1ns/1ps
module test_rrs_exec;
	// ==========================================================
	// Clock, reset and bus signals
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [3:0] wstrb = 4'h0;
	logic [1:0] bresp, rresp;
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	always #5 clock = ~clock;

	rrs_exec #(.ADDR_W(8)) i_dut (.clock(clock), .rstn(rstn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

	// ==========================================================
	// Tasks
	task automatic print_verdict();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : print_verdict

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check

	// Signals are sampled as the task wakes on the edge, before that edge's flop updates land.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
		@(posedge clock);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hf;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, expResp});
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
		@(posedge clock);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge clock);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] expResp);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		check(d, exp);
		check({30'h0, r}, {30'h0, expResp});
	endtask : rdChk

	task automatic memSet(input logic [11:0] a, input logic [7:0] v);
		wr(rrs_pkg::OFF_MADDR, {20'h0, a}, rrs_pkg::RESP_OK);
		wr(rrs_pkg::OFF_MDATA, {24'h0, v}, rrs_pkg::RESP_OK);
	endtask : memSet

	task automatic memChk(input logic [11:0] a, input logic [7:0] v);
		wr(rrs_pkg::OFF_MADDR, {20'h0, a}, rrs_pkg::RESP_OK);
		rdChk(rrs_pkg::OFF_MDATA, {24'h0, v}, rrs_pkg::RESP_OK);
	endtask : memChk

	// For a legal opcode, the first status read lands while the four phases are still running.
	task automatic exec(input logic [15:0] ins, input logic expBusy);
		logic [31:0] d;
		logic [1:0] r;
		int n;
		wr(rrs_pkg::OFF_INSTR, {16'h0, ins}, rrs_pkg::RESP_OK);
		rd(rrs_pkg::OFF_STAT, d, r);
		check({31'h0, d[rrs_pkg::STAT_BUSY]}, {31'h0, expBusy});
		n = 0;
		while (d[rrs_pkg::STAT_BUSY] !== 1'b0 && n < 20) begin
			rd(rrs_pkg::OFF_STAT, d, r);
			n++;
		end
		check({31'h0, d[rrs_pkg::STAT_BUSY]}, 32'h0);
	endtask : exec

	// ==========================================================
	// Timeout
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			print_verdict();
		end
	end

	// ==========================================================
	// Sequence
	initial begin
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		rdChk(rrs_pkg::OFF_STAT, 32'h0, rrs_pkg::RESP_OK);
		rdChk(rrs_pkg::OFF_CFG, 32'h0, rrs_pkg::RESP_OK);
		rdChk(8'h20, 32'h0, rrs_pkg::RESP_ERR);
		wr(8'h20, 32'h12345678, rrs_pkg::RESP_ERR);
		// Rotate into memory from the upper access bank; the bank register must not matter.
		wr(rrs_pkg::OFF_BANK, 32'h3, rrs_pkg::RESP_OK);
		wr(rrs_pkg::OFF_STAT, 32'h0b, rrs_pkg::RESP_OK);
		memSet(12'hf80, 8'hd7);
		memSet(12'h380, 8'h3c);
		exec(16'h4280, 1'b1);
		memChk(12'hf80, 8'heb);
		memChk(12'h380, 8'h3c);
		rdChk(rrs_pkg::OFF_STAT, 32'h1b, rrs_pkg::RESP_OK);
		// Rotate into the working register through the bank register; a zero result sets Z.
		wr(rrs_pkg::OFF_WREG, 32'h55, rrs_pkg::RESP_OK);
		memSet(12'h381, 8'h00);
		exec(16'h4181, 1'b1);
		rdChk(rrs_pkg::OFF_WREG, 32'h00, rrs_pkg::RESP_OK);
		rdChk(rrs_pkg::OFF_STAT, 32'h0f, rrs_pkg::RESP_OK);
		memSet(12'h380, 8'h01);
		exec(16'h4180, 1'b1);
		rdChk(rrs_pkg::OFF_WREG, 32'h80, rrs_pkg::RESP_OK);
		memChk(12'h380, 8'h01);
		rdChk(rrs_pkg::OFF_STAT, 32'h1b, rrs_pkg::RESP_OK);
		// Set-file through the bank register, the upper and the lower access bank.
		wr(rrs_pkg::OFF_BANK, 32'h5, rrs_pkg::RESP_OK);
		memSet(12'h522, 8'h5a);
		memSet(12'hf90, 8'h00);
		memSet(12'h590, 8'h11);
		memSet(12'h05f, 8'h22);
		exec(16'h6922, 1'b1);
		memChk(12'h522, 8'hff);
		exec(16'h6890, 1'b1);
		memChk(12'hf90, 8'hff);
		memChk(12'h590, 8'h11);
		exec(16'h685f, 1'b1);
		memChk(12'h05f, 8'hff);
		rdChk(rrs_pkg::OFF_STAT, 32'h1b, rrs_pkg::RESP_OK);
		// Indexed literal offset mode, its boundary at 5Fh and the 12-bit wrap.
		wr(rrs_pkg::OFF_CFG, 32'h1, rrs_pkg::RESP_OK);
		wr(rrs_pkg::OFF_IDX, 32'h300, rrs_pkg::RESP_OK);
		memSet(12'h310, 8'h02);
		memSet(12'h010, 8'h44);
		memSet(12'h35f, 8'h00);
		memSet(12'hf60, 8'h00);
		exec(16'h4210, 1'b1);
		memChk(12'h310, 8'h01);
		memChk(12'h010, 8'h44);
		exec(16'h685f, 1'b1);
		memChk(12'h35f, 8'hff);
		exec(16'h6860, 1'b1);
		memChk(12'hf60, 8'hff);
		wr(rrs_pkg::OFF_IDX, 32'hff0, rrs_pkg::RESP_OK);
		exec(16'h6820, 1'b1);
		memChk(12'h010, 8'hff);
		// A word matching neither opcode is flagged and changes nothing.
		exec(16'h4410, 1'b0);
		memChk(12'h010, 8'hff);
		rdChk(rrs_pkg::OFF_STAT, 32'h20b, rrs_pkg::RESP_OK);
		// A reset in mid-run clears the registers and the illegal flag.
		rstn <= 1'b0;
		repeat (2) @(posedge clock);
		rstn <= 1'b1;
		rdChk(rrs_pkg::OFF_STAT, 32'h0, rrs_pkg::RESP_OK);
		rdChk(rrs_pkg::OFF_WREG, 32'h0, rrs_pkg::RESP_OK);
		rdChk(rrs_pkg::OFF_IDX, 32'h0, rrs_pkg::RESP_OK);
		rdChk(rrs_pkg::OFF_CFG, 32'h0, rrs_pkg::RESP_OK);
		print_verdict();
	end
endmodule : test_rrs_exec
